// file: verilog/psrc_top.sv
// APB register bank: port 4/5 link status and reduced-MII receive clock output control.
`timescale 1ns/1ps
`include "psrc_regs.svh"

// Function
// - Control bit 3 set stops switch-side receive clock output; clear drives it; resets zero.
// - Control bit 2 set stops PHY-side receive clock output; clear drives it; resets zero.
// - Status bit 5 reads one when cable polarity is reversed; resets zero.
// - Status bit 4 reads one while transmit flow control is active; resets zero.
// - Status bit 3 reads one while receive flow control is active; resets zero.
// - Status bit 2 reads one at 100 Mbps, zero at 10 Mbps.
// - Status bit 1 reads one for full duplex, zero for half; resets zero.
module psrc_top
	import psrc_pkg::*;
#(
	parameter int ADDR_W = 12
)(
	// APB clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [ADDR_W-1:0]       paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Live condition of port 4 (index 0) and port 5 (index 1)
	input  wire psrc_port_status_t [1:0] port_status_in,
	// Receive clock pin enables, low while the pin drives the reference clock
	output logic                         switch_side_rx_clk_oe_n,
	output logic                         phy_side_rx_clk_oe_n,
	// Stored crossover mode bits of port 4 (bit 0) and port 5 (bit 1)
	output logic      [1:0]              auto_crossover_mode
);

	// ------------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------------
	// The highest register sits at byte 0x164, which needs nine address bits.
	if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr_w
		$error("psrc_top: ADDR_W must lie between 9 and 32");
	end

	localparam logic [ADDR_W-1:0] P4_ADDR   = ADDR_W'({`PSRC_IDX_P4_STATUS, 2'b00});
	localparam logic [ADDR_W-1:0] P5_ADDR   = ADDR_W'({`PSRC_IDX_P5_STATUS, 2'b00});
	localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'({`PSRC_IDX_RMII_CTRL, 2'b00});

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	psrc_port_status_t [1:0] port_stat;
	psrc_clk_ctrl_t          clk_ctrl_ff;
	logic [1:0]              autox_ff;
	logic [31:0]             prdata_ff;
	logic                    pready_ff;
	logic                    pslverr_ff;
	logic                    hit_p4;
	logic                    hit_p5;
	logic                    hit_ctrl;
	logic                    setup;
	logic                    wr_done;
	logic [7:0]              nxt_rdata;

	// ------------------------------------------------------------------------
	// Status capture
	// ------------------------------------------------------------------------
	for (genvar p = 0; p < 2; p++) begin : g_port
		psrc_port_status u_status (
			.pclk      (pclk),
			.presetn   (presetn),
			.status_in (port_status_in[p]),
			.status_ff (port_stat[p])
		);
	end

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	assign hit_p4   = (paddr == P4_ADDR);
	assign hit_p5   = (paddr == P5_ADDR);
	assign hit_ctrl = (paddr == CTRL_ADDR);
	assign setup    = psel && !penable;
	// A write lands only at the access edge that also sees pready, and never on an error.
	assign wr_done  = psel && penable && pready_ff && pwrite && !pslverr_ff && pstrb[0];

	always_comb begin
		nxt_rdata = 8'h00;
		if (hit_p4 || hit_p5) begin
			nxt_rdata[`PSRC_ST_AUTOX_BIT]  = hit_p5 ? autox_ff[1] : autox_ff[0];
			nxt_rdata[`PSRC_ST_POL_BIT]    = port_stat[hit_p5].polarity_reversed;
			nxt_rdata[`PSRC_ST_TXFC_BIT]   = port_stat[hit_p5].tx_flow_ctrl_active;
			nxt_rdata[`PSRC_ST_RXFC_BIT]   = port_stat[hit_p5].rx_flow_ctrl_active;
			nxt_rdata[`PSRC_ST_SPEED_BIT]  = port_stat[hit_p5].speed_100;
			nxt_rdata[`PSRC_ST_DUPLEX_BIT] = port_stat[hit_p5].full_duplex;
		end else if (hit_ctrl) begin
			nxt_rdata[`PSRC_CTRL_SW_DIS_BIT]  = clk_ctrl_ff.switch_side_reduced_mii_dis;
			nxt_rdata[`PSRC_CTRL_PHY_DIS_BIT] = clk_ctrl_ff.phy_side_reduced_mii_dis;
		end
	end

	// ------------------------------------------------------------------------
	// APB answer
	// ------------------------------------------------------------------------
	// No wait state: the answer is prepared at the setup edge so every output is a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
		end else begin
			pready_ff <= setup;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_ff <= 1'b0;
		end else begin
			pslverr_ff <= setup && !(hit_p4 || hit_p5 || hit_ctrl);
		end
	end

	// Unused upper bits and reserved fields always read zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup) begin
			prdata_ff <= pwrite ? 32'h0000_0000 : {24'h00_0000, nxt_rdata};
		end
	end

	// ------------------------------------------------------------------------
	// Writable fields
	// ------------------------------------------------------------------------
	// Only the two disable bits take write data; bits 7..4 and 1..0 are dropped.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_ctrl_ff.switch_side_reduced_mii_dis <= `PSRC_CTRL_SW_DIS_RST;
			clk_ctrl_ff.phy_side_reduced_mii_dis    <= `PSRC_CTRL_PHY_DIS_RST;
		end else if (wr_done && hit_ctrl) begin
			clk_ctrl_ff.switch_side_reduced_mii_dis <= pwdata[`PSRC_CTRL_SW_DIS_BIT];
			clk_ctrl_ff.phy_side_reduced_mii_dis    <= pwdata[`PSRC_CTRL_PHY_DIS_BIT];
		end
	end

	// Status registers keep only the crossover mode bit; the read-only fields ignore writes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			autox_ff <= {2{`PSRC_ST_AUTOX_RST}};
		end else if (wr_done && hit_p4) begin
			autox_ff[0] <= pwdata[`PSRC_ST_AUTOX_BIT];
		end else if (wr_done && hit_p5) begin
			autox_ff[1] <= pwdata[`PSRC_ST_AUTOX_BIT];
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	// A disable bit simply releases the pin; the board must then supply the reference.
	assign switch_side_rx_clk_oe_n = clk_ctrl_ff.switch_side_reduced_mii_dis;
	assign phy_side_rx_clk_oe_n    = clk_ctrl_ff.phy_side_reduced_mii_dis;
	assign auto_crossover_mode     = autox_ff;
	assign prdata                  = prdata_ff;
	assign pready                  = pready_ff;
	assign pslverr                 = pslverr_ff;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic rd_p4;
	logic rd_p5;
	logic rd_ctrl;
	assign rd_p4   = setup && !pwrite && hit_p4;
	assign rd_p5   = setup && !pwrite && hit_p5;
	assign rd_ctrl = setup && !pwrite && hit_ctrl;

	property p_sw_dis;
		wr_done && hit_ctrl |=> switch_side_rx_clk_oe_n == $past(pwdata[`PSRC_CTRL_SW_DIS_BIT]);
	endproperty
	a_sw_dis: assert property (p_sw_dis) else $error("switch-side clock enable missed write");

	property p_phy_hold;
		!(wr_done && hit_ctrl) |=> $stable(phy_side_rx_clk_oe_n) && $stable(switch_side_rx_clk_oe_n);
	endproperty
	a_phy_hold: assert property (p_phy_hold) else $error("clock enable changed without write");

	property p_pol;
		rd_p4 |=> prdata[`PSRC_ST_POL_BIT] == $past(port_status_in[0].polarity_reversed, 2);
	endproperty
	a_pol: assert property (p_pol) else $error("polarity bit wrong");

	property p_txfc;
		rd_p5 |=> pready && prdata[`PSRC_ST_TXFC_BIT] == $past(port_status_in[1].tx_flow_ctrl_active, 2);
	endproperty
	a_txfc: assert property (p_txfc) else $error("transmit flow control bit wrong");

	property p_rxfc;
		rd_p4 |=> prdata[`PSRC_ST_RXFC_BIT] == $past(port_stat[0].rx_flow_ctrl_active);
	endproperty
	a_rxfc: assert property (p_rxfc) else $error("receive flow control bit wrong");

	property p_speed;
		rd_p5 |=> prdata[`PSRC_ST_SPEED_BIT] == $past(port_stat[1].speed_100);
	endproperty
	a_speed: assert property (p_speed) else $error("speed bit wrong");

	property p_duplex;
		rd_p4 ##1 pready |-> prdata[`PSRC_ST_DUPLEX_BIT] == $past(port_status_in[0].full_duplex, 2);
	endproperty
	a_duplex: assert property (p_duplex) else $error("duplex bit wrong");

	property p_rsvd;
		(rd_p4 || rd_p5 || rd_ctrl) |=> prdata[31:8] == 24'h00_0000 && !prdata[`PSRC_ST_RSVD0_BIT]
			&& (!$past(hit_ctrl) || (prdata[7:4] == 4'h0 && prdata[1] == 1'b0));
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

	property p_unmapped;
		setup && !(hit_p4 || hit_p5 || hit_ctrl) |=> pready && pslverr ##1 $stable(clk_ctrl_ff);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

	c_sw_disable:  cover property (wr_done && hit_ctrl && pwdata[`PSRC_CTRL_SW_DIS_BIT]);
	c_phy_disable: cover property (wr_done && hit_ctrl && pwdata[`PSRC_CTRL_PHY_DIS_BIT]);
	c_read_p5:     cover property (rd_p5 ##1 prdata[`PSRC_ST_SPEED_BIT]);
	c_error:       cover property (pready && pslverr);

endmodule

// file: shared/psrc_regs.svh
// Register indices, field positions, reset values and timing for the port status and clock control bank.
`ifndef PSRC_REGS_SVH
`define PSRC_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PSRC_IDX_P4_STATUS     8'h49
`define PSRC_IDX_P5_STATUS     8'h59
`define PSRC_IDX_RMII_CTRL     8'h57

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define PSRC_CTRL_SW_DIS_BIT   3
`define PSRC_CTRL_PHY_DIS_BIT  2
`define PSRC_CTRL_SW_DIS_RST   1'b0
`define PSRC_CTRL_PHY_DIS_RST  1'b0

// ----------------------------------------------------------------------------
// Port status register fields
// ----------------------------------------------------------------------------
`define PSRC_ST_AUTOX_BIT      7
`define PSRC_ST_RSVD6_BIT      6
`define PSRC_ST_POL_BIT        5
`define PSRC_ST_TXFC_BIT       4
`define PSRC_ST_RXFC_BIT       3
`define PSRC_ST_SPEED_BIT      2
`define PSRC_ST_DUPLEX_BIT     1
`define PSRC_ST_RSVD0_BIT      0
`define PSRC_ST_AUTOX_RST      1'b1

// ----------------------------------------------------------------------------
// Bus timing: cycles from setup edge to pready high
// ----------------------------------------------------------------------------
`define PSRC_APB_WAIT_CYC      1

`endif

// file: shared/psrc_pkg.sv
// Types shared by the port status and clock control bank.
package psrc_pkg;

	// Live link condition of one port, as reported by the PHY and MAC.
	typedef struct packed {
		logic polarity_reversed;
		logic tx_flow_ctrl_active;
		logic rx_flow_ctrl_active;
		logic speed_100;
		logic full_duplex;
	} psrc_port_status_t;

	// Clock output disable controls of the fifth port's reduced-MII interfaces.
	typedef struct packed {
		logic switch_side_reduced_mii_dis;
		logic phy_side_reduced_mii_dis;
	} psrc_clk_ctrl_t;

endpackage

// file: verilog/psrc_port_status.sv
// Per-port capture of the live link condition into reset-clean status flops.
`timescale 1ns/1ps
`include "psrc_regs.svh"

module psrc_port_status
	import psrc_pkg::*;
(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// Live condition and registered copy
	input  wire psrc_port_status_t status_in,
	output psrc_port_status_t      status_ff
);

	// ------------------------------------------------------------------------
	// Capture
	// ------------------------------------------------------------------------
	// Every field clears at reset, so software never sees a stale condition.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff <= '0;
		end else begin
			status_ff <= status_in;
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	property p_status_track;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> status_ff == $past(status_in);
	endproperty
	a_status_track: assert property (p_status_track) else $error("status copy lags input");

endmodule

// file: tb/psrc_top_tb.sv
// Self-checking testbench for the port status and reduced-MII clock control register bank.
`timescale 1ns/1ps
`include "psrc_regs.svh"

module psrc_top_tb
	import psrc_pkg::*;
;
	typedef struct {
		logic        rd;
		logic [31:0] data;
		logic        err;
	} psrc_tb_note_t;

	localparam logic [11:0] A_P4   = {2'b00, `PSRC_IDX_P4_STATUS, 2'b00};
	localparam logic [11:0] A_P5   = {2'b00, `PSRC_IDX_P5_STATUS, 2'b00};
	localparam logic [11:0] A_CTRL = {2'b00, `PSRC_IDX_RMII_CTRL, 2'b00};

	logic                    pclk;
	logic                    presetn;
	logic                    psel;
	logic                    penable;
	logic                    pwrite;
	logic [11:0]             paddr;
	logic [31:0]             pwdata;
	logic [3:0]              pstrb;
	logic [31:0]             prdata;
	logic                    pready;
	logic                    pslverr;
	psrc_port_status_t [1:0] st_in;
	logic                    switch_side_rx_clk_oe_n;
	logic                    phy_side_rx_clk_oe_n;
	logic [1:0]              auto_crossover_mode;
	psrc_tb_note_t           exp_q[$];
	int                      err_total;
	int                      checks;
	int                      cyc;
	logic [1:0]              ctrl_m;
	logic [1:0]              xov_m;

	psrc_top i_psrc_top (
		.pclk                    (pclk),
		.presetn                 (presetn),
		.psel                    (psel),
		.penable                 (penable),
		.pwrite                  (pwrite),
		.paddr                   (paddr),
		.pwdata                  (pwdata),
		.pstrb                   (pstrb),
		.prdata                  (prdata),
		.pready                  (pready),
		.pslverr                 (pslverr),
		.port_status_in          (st_in),
		.switch_side_rx_clk_oe_n (switch_side_rx_clk_oe_n),
		.phy_side_rx_clk_oe_n    (phy_side_rx_clk_oe_n),
		.auto_crossover_mode     (auto_crossover_mode)
	);

	// ------------------------------------------------------------------------
	// Clock, timeout and reporting
	// ------------------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// The whole run needs about 300 cycles; the ceiling leaves ample slack.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_total++;
			end_sim();
		end
	end

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, e, g);
		end
	endtask

	// ------------------------------------------------------------------------
	// Bus driver and response monitor
	// ------------------------------------------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [7:0] e, input logic er);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		exp_q.push_back('{rd: !wr, data: {24'h0, e}, err: er});
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout may end this wait; the slave decides how long it takes.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Responses are judged at the edge that completes the access, when prdata is valid.
	always @(posedge pclk) begin
		psrc_tb_note_t nt;
		if (presetn === 1'b1 && pready === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("unexpected_ready", 32'h0, 32'h1);
			end else begin
				nt = exp_q.pop_front();
				chk("pslverr", {31'h0, nt.err}, {31'h0, pslverr});
				if (nt.rd) begin
					chk("prdata", nt.data, prdata);
				end
			end
		end
	end

	function automatic logic [7:0] st_byte(input int p);
		return {xov_m[p], 1'b0, st_in[p], 1'b0};
	endfunction

	task automatic chk_pins();
		@(negedge pclk);
		chk("switch_side_rx_clk_oe_n", {31'h0, ctrl_m[1]}, {31'h0, switch_side_rx_clk_oe_n});
		chk("phy_side_rx_clk_oe_n", {31'h0, ctrl_m[0]}, {31'h0, phy_side_rx_clk_oe_n});
		chk("auto_crossover_mode", {30'h0, xov_m}, {30'h0, auto_crossover_mode});
	endtask

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [11:0] bad [4];
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		st_in = '0;
		err_total = 0;
		checks = 0;
		cyc = 0;
		ctrl_m = 2'b00;
		xov_m = 2'b11;
		bad = '{12'h000, 12'h125, 12'h15e, 12'hffc};
		void'($urandom(96));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		chk_pins();
		apb(1'b0, A_CTRL, 32'h0, 4'h0, 8'h00, 1'b0);
		apb(1'b0, A_P4, 32'h0, 4'h0, 8'h80, 1'b0);
		apb(1'b0, A_P5, 32'h0, 4'h0, 8'h80, 1'b0);
		$display("test reset values done");
		// Writes without the low byte strobe must leave the control bits alone.
		for (int i = 0; i < 8; i++) begin
			d = $urandom;
			d[3:2] = i[1:0];
			apb(1'b1, A_CTRL, d, i[2] ? 4'he : 4'hf, 8'h00, 1'b0);
			if (!i[2]) begin
				ctrl_m = d[3:2];
			end
			chk_pins();
			apb(1'b0, A_CTRL, 32'h0, 4'h0, {4'h0, ctrl_m, 2'b00}, 1'b0);
		end
		$display("test clock output control done");
		for (int i = 0; i < 16; i++) begin
			@(posedge pclk);
			st_in <= 10'($urandom);
			d = $urandom;
			apb(1'b1, i[0] ? A_P5 : A_P4, d, 4'hf, 8'h00, 1'b0);
			xov_m[i[0]] = d[7];
			repeat (2) @(posedge pclk);
			apb(1'b0, A_P4, 32'h0, 4'h0, st_byte(0), 1'b0);
			apb(1'b0, A_P5, 32'h0, 4'h0, st_byte(1), 1'b0);
		end
		chk_pins();
		$display("test port status done");
		// A reset in mid-run must return both disable bits and the crossover bits to their defaults.
		@(posedge pclk);
		presetn <= 1'b0;
		ctrl_m = 2'b00;
		xov_m = 2'b11;
		chk_pins();
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, A_CTRL, 32'h0, 4'h0, 8'h00, 1'b0);
		apb(1'b0, A_P5, 32'h0, 4'h0, st_byte(1), 1'b0);
		chk_pins();
		$display("test mid-run reset done");
		foreach (bad[k]) begin
			apb(1'b1, bad[k], 32'hffff_ffff, 4'hf, 8'h00, 1'b1);
			apb(1'b0, bad[k], 32'h0, 4'h0, 8'h00, 1'b1);
		end
		apb(1'b0, A_CTRL, 32'h0, 4'h0, {4'h0, ctrl_m, 2'b00}, 1'b0);
		chk_pins();
		$display("test unmapped access done");
		repeat (2) @(posedge pclk);
		chk("pending_notes", 32'h0, exp_q.size());
		end_sim();
	end

endmodule
